/* design/fidr_pkg.sv */
package fidr_pkg;
    // Opcodes
    localparam logic [7:0] OP_QUAD_ID = 8'h94;
    localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
    localparam logic [7:0] OP_STD_ID = 8'h9F;
    localparam logic [7:0] OP_DISCOVERY = 8'h5A;
    localparam logic [23:0] SWAP_ADDR = 24'h000001;
    localparam logic [7:0] MODE_FILL = 8'hF0;
    // Phase lengths in link clocks
    localparam int OPC_CLKS = 8;
    localparam int QID_ADDR_CLKS = 6;
    localparam int QID_MODE_CLKS = 2;
    localparam int QID_DUMMY_CLKS = 4;
    localparam int UID_DUMMY_CLKS = 32;
    localparam int DISC_ADDR_CLKS = 24;
    localparam int DISC_DUMMY_CLKS = 8;
    localparam int QID_START = OPC_CLKS + QID_ADDR_CLKS + QID_MODE_CLKS + QID_DUMMY_CLKS;
    localparam int UID_START = OPC_CLKS + UID_DUMMY_CLKS;
    localparam int DISC_START = OPC_CLKS + DISC_ADDR_CLKS + DISC_DUMMY_CLKS;
    // Discovery area byte offsets and contents
    localparam logic [7:0] OFS_SIG0 = 8'h00;
    localparam logic [7:0] OFS_SIG1 = 8'h01;
    localparam logic [7:0] OFS_SIG2 = 8'h02;
    localparam logic [7:0] OFS_SIG3 = 8'h03;
    localparam logic [7:0] OFS_MINOR = 8'h04;
    localparam logic [7:0] OFS_MAJOR = 8'h05;
    localparam logic [7:0] OFS_HDR_COUNT = 8'h06;
    localparam logic [7:0] OFS_RSVD07 = 8'h07;
    localparam logic [7:0] OFS_HDR_ID = 8'h08;
    localparam logic [7:0] OFS_TBL_MINOR = 8'h09;
    localparam logic [7:0] OFS_TBL_MAJOR = 8'h0A;
    localparam logic [7:0] OFS_TBL_LEN = 8'h0B;
    localparam logic [7:0] OFS_PTR_LOW = 8'h0C;
    localparam logic [7:0] OFS_PTR_MID = 8'h0D;
    localparam logic [7:0] VAL_SIG0 = 8'h53;
    localparam logic [7:0] VAL_SIG1 = 8'h46;
    localparam logic [7:0] VAL_SIG2 = 8'h44;
    localparam logic [7:0] VAL_SIG3 = 8'h50;
    localparam logic [7:0] VAL_MINOR = 8'h00;
    localparam logic [7:0] VAL_MAJOR = 8'h01;
    localparam logic [7:0] VAL_HDR_COUNT = 8'h00;
    localparam logic [7:0] VAL_RSVD = 8'hFF;
    localparam logic [7:0] VAL_HDR_ID = 8'h00;
    localparam logic [7:0] VAL_TBL_MINOR = 8'h00;
    localparam logic [7:0] VAL_TBL_MAJOR = 8'h01;
    localparam logic [7:0] VAL_TBL_LEN = 8'h09;
    localparam logic [7:0] VAL_PTR_LOW = 8'h80;
    localparam logic [7:0] VAL_PTR_MID = 8'h00;
    // Controller register map and fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0C;
    localparam logic [7:0] REG_RX_LO = 8'h10;
    localparam logic [7:0] REG_RX_HI = 8'h14;
    localparam int CTRL_START_BIT = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    // Link clock timing: 40 MHz divided by 2 x 4 gives 200 ns per link clock
    localparam real CLK_PERIOD_NS = 25.0;
    localparam real SCLK_HALF_NS = 100.0;
    localparam int SCLK_HALF_CYCLES = int'(SCLK_HALF_NS / CLK_PERIOD_NS);
endpackage

/* design/fidr_link_if.sv */
`timescale 1ns/1ps
interface fidr_link_if;
    logic cs_n;
    logic sclk;
    logic [3:0] host_io;
    logic [3:0] host_oe;
    logic [3:0] dev_io;
    logic [3:0] dev_oe;
    logic [3:0] io;
    // Wire level: whoever enables wins, undriven lines float high
    assign io = (host_io & host_oe) | (dev_io & dev_oe) | ~(host_oe | dev_oe);
    modport host (output cs_n, output sclk, output host_io, output host_oe, input io);
    modport dev (input cs_n, input sclk, input io, output dev_io, output dev_oe);
endinterface

/* design/fidr_device.sv */
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module fidr_device #(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h15, // Arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h40, // Arbitrary value
    parameter logic [7:0] CAPACITY = 8'h16, // Arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // Arbitrary value
) (
    input wire logic rst_n_i,
    fidr_link_if.dev link
);
    typedef enum logic [2:0] {
        FIDR_ST_CMD = 3'b000,
        FIDR_ST_ADDR = 3'b001,
        FIDR_ST_MODE = 3'b010,
        FIDR_ST_DUMMY = 3'b011,
        FIDR_ST_DATA = 3'b100,
        FIDR_ST_IGNORE = 3'b101
    } fidr_state_t;

    typedef enum logic [1:0] {
        FIDR_K_QUAD = 2'b00,
        FIDR_K_UNIQUE = 2'b01,
        FIDR_K_STD = 2'b10,
        FIDR_K_DISC = 2'b11
    } fidr_kind_t;

    fidr_state_t st_q;
    fidr_kind_t kind_q;
    logic [5:0] ph_q;
    logic [7:0] opc_q;
    logic [23:0] addr_q;
    logic [7:0] continuous_read_mode_bits_q;
    logic [10:0] ocnt_q;
    logic [3:0] io_q;
    logic [3:0] oe_q;
    logic link_rst_n;
    logic [7:0] opc_d;
    logic [7:0] disc_addr;
    logic [7:0] disc_byte;
    logic [7:0] qid_byte;
    logic [7:0] std_byte;

    // Deselect is an asynchronous reset of the whole link logic
    assign link_rst_n = rst_n_i & link.cs_n == 1'b0;
    assign opc_d = {opc_q[6:0], link.io[0]};

    // The link clock stops between frames, so each phase ends on a count
    always_ff @(posedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            st_q <= FIDR_ST_CMD;
            ph_q <= 6'h00;
            kind_q <= FIDR_K_QUAD;
        end else begin
            ph_q <= ph_q + 6'h01;
            case (st_q)
                FIDR_ST_CMD: begin
                    if (ph_q == 6'(fidr_pkg::OPC_CLKS - 1)) begin
                        ph_q <= 6'h00;
                        case (opc_d)
                            fidr_pkg::OP_QUAD_ID: begin
                                kind_q <= FIDR_K_QUAD;
                                st_q <= FIDR_ST_ADDR;
                            end
                            fidr_pkg::OP_UNIQUE_ID: begin
                                kind_q <= FIDR_K_UNIQUE;
                                st_q <= FIDR_ST_DUMMY;
                            end
                            fidr_pkg::OP_STD_ID: begin
                                kind_q <= FIDR_K_STD;
                                st_q <= FIDR_ST_DATA;
                            end
                            fidr_pkg::OP_DISCOVERY: begin
                                kind_q <= FIDR_K_DISC;
                                st_q <= FIDR_ST_ADDR;
                            end
                            default: st_q <= FIDR_ST_IGNORE;
                        endcase
                    end
                end
                FIDR_ST_ADDR: begin
                    if (kind_q == FIDR_K_QUAD && ph_q == 6'(fidr_pkg::QID_ADDR_CLKS - 1)) begin
                        ph_q <= 6'h00;
                        st_q <= FIDR_ST_MODE;
                    end else if (kind_q == FIDR_K_DISC
                            && ph_q == 6'(fidr_pkg::DISC_ADDR_CLKS - 1)) begin
                        ph_q <= 6'h00;
                        st_q <= FIDR_ST_DUMMY;
                    end
                end
                FIDR_ST_MODE: begin
                    if (ph_q == 6'(fidr_pkg::QID_MODE_CLKS - 1)) begin
                        ph_q <= 6'h00;
                        st_q <= FIDR_ST_DUMMY;
                    end
                end
                FIDR_ST_DUMMY: begin
                    if ((kind_q == FIDR_K_QUAD && ph_q == 6'(fidr_pkg::QID_DUMMY_CLKS - 1))
                            || (kind_q == FIDR_K_UNIQUE
                            && ph_q == 6'(fidr_pkg::UID_DUMMY_CLKS - 1))
                            || (kind_q == FIDR_K_DISC
                            && ph_q == 6'(fidr_pkg::DISC_DUMMY_CLKS - 1))) begin
                        st_q <= FIDR_ST_DATA;
                    end
                end
                FIDR_ST_DATA: ph_q <= 6'h00; // Stays until deselect
                FIDR_ST_IGNORE: ph_q <= 6'h00; // Unknown opcodes wait for deselect
                default: st_q <= FIDR_ST_IGNORE;
            endcase
        end
    end

    // Opcode shifts in serially, most significant bit first
    always_ff @(posedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            opc_q <= 8'h00;
        end else if (st_q == FIDR_ST_CMD) begin
            opc_q <= opc_d;
        end
    end

    // Address: four lines per clock for quad ID, one line for discovery
    always_ff @(posedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            addr_q <= 24'h000000;
        end else if (st_q == FIDR_ST_ADDR && kind_q == FIDR_K_QUAD) begin
            addr_q <= {addr_q[19:0], link.io};
        end else if (st_q == FIDR_ST_ADDR) begin
            addr_q <= {addr_q[22:0], link.io[0]};
        end
    end

    // Mode bits are taken but not acted on; the host owes Fxh here
    always_ff @(posedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            continuous_read_mode_bits_q <= 8'h00;
        end else if (st_q == FIDR_ST_MODE) begin
            continuous_read_mode_bits_q <= {continuous_read_mode_bits_q[3:0], link.io};
        end
    end

    // High address bits are ignored; a host that breaks the zero rule still reads a wrap
    assign disc_addr = addr_q[7:0] + ocnt_q[10:3];

    // Discovery area contents, fixed in logic
    always_comb begin
        case (disc_addr)
            fidr_pkg::OFS_SIG0: disc_byte = fidr_pkg::VAL_SIG0;
            fidr_pkg::OFS_SIG1: disc_byte = fidr_pkg::VAL_SIG1;
            fidr_pkg::OFS_SIG2: disc_byte = fidr_pkg::VAL_SIG2;
            fidr_pkg::OFS_SIG3: disc_byte = fidr_pkg::VAL_SIG3;
            fidr_pkg::OFS_MINOR: disc_byte = fidr_pkg::VAL_MINOR;
            fidr_pkg::OFS_MAJOR: disc_byte = fidr_pkg::VAL_MAJOR;
            fidr_pkg::OFS_HDR_COUNT: disc_byte = fidr_pkg::VAL_HDR_COUNT;
            fidr_pkg::OFS_RSVD07: disc_byte = fidr_pkg::VAL_RSVD;
            fidr_pkg::OFS_HDR_ID: disc_byte = fidr_pkg::VAL_HDR_ID;
            fidr_pkg::OFS_TBL_MINOR: disc_byte = fidr_pkg::VAL_TBL_MINOR;
            fidr_pkg::OFS_TBL_MAJOR: disc_byte = fidr_pkg::VAL_TBL_MAJOR;
            fidr_pkg::OFS_TBL_LEN: disc_byte = fidr_pkg::VAL_TBL_LEN;
            fidr_pkg::OFS_PTR_LOW: disc_byte = fidr_pkg::VAL_PTR_LOW;
            fidr_pkg::OFS_PTR_MID: disc_byte = fidr_pkg::VAL_PTR_MID;
            default: disc_byte = fidr_pkg::VAL_RSVD;
        endcase
    end

    // Quad ID alternates codes every byte; address 000001h flips the start
    assign qid_byte = (ocnt_q[1] ^ (addr_q == fidr_pkg::SWAP_ADDR))
        ? DEVICE_CODE : MAKER_CODE;

    // Standard ID: maker, type, capacity, then one filler byte, repeating
    always_comb begin
        case (ocnt_q[4:3])
            2'h0: std_byte = MAKER_CODE;
            2'h1: std_byte = MEM_TYPE;
            2'h2: std_byte = CAPACITY;
            default: std_byte = fidr_pkg::VAL_RSVD;
        endcase
    end

    // Output changes on the falling edge so the host samples a settled bit
    always_ff @(negedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            io_q <= 4'h0;
            oe_q <= 4'h0;
            ocnt_q <= 11'h000;
        end else if (st_q == FIDR_ST_DATA) begin
            ocnt_q <= ocnt_q + 11'h001;
            case (kind_q)
                FIDR_K_QUAD: begin
                    oe_q <= 4'hF;
                    io_q <= ocnt_q[0] ? qid_byte[3:0] : qid_byte[7:4];
                end
                FIDR_K_UNIQUE: begin
                    oe_q <= 4'h2;
                    io_q <= {2'b00, UNIQUE_ID[~ocnt_q[5:0]], 1'b0};
                end
                FIDR_K_STD: begin
                    oe_q <= 4'h2;
                    io_q <= {2'b00, std_byte[~ocnt_q[2:0]], 1'b0};
                end
                default: begin
                    oe_q <= 4'h2;
                    io_q <= {2'b00, disc_byte[~ocnt_q[2:0]], 1'b0};
                end
            endcase
        end
    end

    assign link.dev_io = io_q;
    assign link.dev_oe = oe_q;
endmodule // fidr_device

/* design/fidr_host.sv */
`timescale 1ns/1ps
module fidr_host #(
    parameter int HALF_CYCLES = fidr_pkg::SCLK_HALF_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    fidr_link_if.host link
);
    typedef enum logic [1:0] {
        FIDR_H_IDLE = 2'b00,
        FIDR_H_RUN = 2'b01,
        FIDR_H_END = 2'b10
    } fidr_hstate_t;

    fidr_hstate_t st_q;
    logic [7:0] opc_q;
    logic [23:0] addr_q;
    logic [7:0] count_q;
    logic done_q;
    logic [63:0] rx_q;
    logic cs_q;
    logic sclk_q;
    logic [3:0] io_q;
    logic [3:0] oe_q;
    logic [7:0] div_q;
    logic [11:0] clk_q;
    logic [11:0] start_clk;
    logic [11:0] total_clk;
    logic quad;
    logic [3:0] in_s1_q;
    logic [3:0] in_s2_q;
    logic tick;
    logic go;

    // Link clock index where data starts, per opcode
    always_comb begin
        case (opc_q)
            fidr_pkg::OP_QUAD_ID: start_clk = 12'(fidr_pkg::QID_START);
            fidr_pkg::OP_UNIQUE_ID: start_clk = 12'(fidr_pkg::UID_START);
            fidr_pkg::OP_DISCOVERY: start_clk = 12'(fidr_pkg::DISC_START);
            default: start_clk = 12'(fidr_pkg::OPC_CLKS);
        endcase
    end
    assign quad = opc_q == fidr_pkg::OP_QUAD_ID;
    assign total_clk = start_clk + (quad ? {3'h0, count_q, 1'b0} : {1'h0, count_q, 3'h0});
    assign tick = div_q == 8'(HALF_CYCLES - 1);
    assign go = wr_i && addr_i == fidr_pkg::REG_CTRL && wdata_i[fidr_pkg::CTRL_START_BIT];

    // What the host presents for link clock number c (counted from zero)
    function automatic logic [7:0] drive(input logic [7:0] op, input logic [23:0] a,
            input logic [11:0] c);
        logic [7:0] r;
        r = 8'h00;
        if (c < 12'(fidr_pkg::OPC_CLKS)) begin
            r = {4'h1, 3'h0, op[3'(~c[2:0])]};
        end else if (op == fidr_pkg::OP_QUAD_ID && c < 12'(fidr_pkg::OPC_CLKS
                + fidr_pkg::QID_ADDR_CLKS)) begin
            r = {4'hF, a[5'(4 * (13 - 32'(c))) +: 4]};
        end else if (op == fidr_pkg::OP_QUAD_ID && c < 12'(fidr_pkg::QID_START
                - fidr_pkg::QID_DUMMY_CLKS)) begin
            r = {4'hF, c[0] ? fidr_pkg::MODE_FILL[3:0] : fidr_pkg::MODE_FILL[7:4]};
        end else if (op == fidr_pkg::OP_DISCOVERY && c < 12'(fidr_pkg::OPC_CLKS
                + fidr_pkg::DISC_ADDR_CLKS)) begin
            r = {4'h1, 3'h0, a[5'(31 - 32'(c))]};
        end
        return r;
    endfunction

    // Device lines are a foreign domain: two flops before use
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_s1_q <= 4'h0;
            in_s2_q <= 4'h0;
        end else begin
            in_s1_q <= link.io;
            in_s2_q <= in_s1_q;
        end
    end

    // Command registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opc_q <= 8'h00;
            addr_q <= 24'h000000;
            count_q <= 8'h00;
        end else if (wr_i && st_q == FIDR_H_IDLE) begin
            if (addr_i == fidr_pkg::REG_CTRL) opc_q <= wdata_i[7:0];
            if (addr_i == fidr_pkg::REG_ADDR) addr_q <= wdata_i[23:0];
            if (addr_i == fidr_pkg::REG_COUNT) count_q <= wdata_i[7:0];
        end
    end

    // Frame sequencer: divides clock_i into the link clock
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= FIDR_H_IDLE;
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
            io_q <= 4'h0;
            oe_q <= 4'h0;
            div_q <= 8'h00;
            clk_q <= 12'h000;
            done_q <= 1'b0;
            rx_q <= 64'h0;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            case (st_q)
                FIDR_H_IDLE: begin
                    if (go) begin
                        st_q <= FIDR_H_RUN;
                        cs_q <= 1'b0;
                        div_q <= 8'h00;
                        clk_q <= 12'h000;
                        done_q <= 1'b0;
                        {oe_q, io_q} <= drive(wdata_i[7:0], addr_q, 12'h000);
                    end
                end
                FIDR_H_RUN: begin
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                        clk_q <= clk_q + 12'h001;
                        if (clk_q >= start_clk) begin
                            rx_q <= quad ? {rx_q[59:0], in_s2_q} : {rx_q[62:0], in_s2_q[1]};
                        end
                    end else if (tick && clk_q == total_clk) begin
                        cs_q <= 1'b1;
                        oe_q <= 4'h0;
                        st_q <= FIDR_H_END;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        {oe_q, io_q} <= drive(opc_q, addr_q, clk_q);
                    end
                end
                FIDR_H_END: begin
                    if (tick) begin
                        sclk_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= FIDR_H_IDLE;
                    end
                end
                default: st_q <= FIDR_H_IDLE;
            endcase
        end
    end

    // Read data stand one cycle after the strobe
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                fidr_pkg::REG_CTRL: rdata_o <= {24'h0, opc_q};
                fidr_pkg::REG_STATUS: rdata_o <= {30'h0, done_q, st_q != FIDR_H_IDLE};
                fidr_pkg::REG_ADDR: rdata_o <= {8'h0, addr_q};
                fidr_pkg::REG_COUNT: rdata_o <= {24'h0, count_q};
                fidr_pkg::REG_RX_LO: rdata_o <= rx_q[31:0];
                fidr_pkg::REG_RX_HI: rdata_o <= rx_q[63:32];
                default: rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

    assign link.cs_n = cs_q;
    assign link.sclk = sclk_q;
    assign link.host_io = io_q;
    assign link.host_oe = oe_q;
endmodule // fidr_host

/* bench/fidr_link_monitor.sv */
`timescale 1ns/1ps
module fidr_link_monitor (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] host_io,
    input wire logic [3:0] host_oe,
    input wire logic [3:0] dev_io,
    input wire logic [3:0] dev_oe,
    input wire logic [3:0] io
);
    logic sclk_q;
    logic [11:0] cnt_q;
    logic [7:0] op_q;
    logic rise;
    int start;
    assign rise = sclk & ~sclk_q;
    // First data clock per opcode; an unknown opcode must never start
    assign start = (op_q == 8'h9F) ? 8 : (op_q == 8'h94) ? 20 :
        (op_q == 8'h4B || op_q == 8'h5A) ? 40 : 4095;
    // Link clock is a host flop, so edges are seen one system clock late
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) sclk_q <= 1'b0;
        else sclk_q <= sclk;
    end
    // Rising link clocks since select, wide enough for a full frame
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_q <= 12'h000;
        else if (cs_n) cnt_q <= 12'h000;
        else if (rise) cnt_q <= cnt_q + 12'h001;
    end
    // Opcode as the device sees it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) op_q <= 8'h00;
        else if (rise && cnt_q < 12'd8) op_q <= {op_q[6:0], io[0]};
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_quiet_deselect: assert property (cs_n |-> dev_oe == 4'h0)
        else $error("device drives while deselected");
    a_no_contention: assert property ((host_oe & dev_oe) == 4'h0)
        else $error("both ends drive the link");
    a_data_start: assert property ($rose(dev_oe != 4'h0) |-> cnt_q == start)
        else $error("device output starts at the wrong clock");
    a_lane_width: assert property (dev_oe != 4'h0 |->
        dev_oe == ((op_q == 8'h94) ? 4'hF : 4'h2)) else $error("wrong output lanes");
    a_fall_launch: assert property (!cs_n && $changed({dev_io, dev_oe}) |-> $fell(sclk))
        else $error("device output changes off the falling edge");
    // Host lines are looked at one system clock after each link rise, while the bit still stands
    a_mode_ones: assert property (rise && op_q == 8'h94 && cnt_q == 12'h00E |->
        host_oe == 4'hF && host_io == 4'hF) else $error("mode nibble not all ones");
    // Last address nibble is left out: the swap start address sets it to 1
    a_quad_addr: assert property (rise && op_q == 8'h94
        && cnt_q inside {[12'h008:12'h00C]} |-> host_oe == 4'hF && host_io == 4'h0)
        else $error("quad address not zero");
    a_disc_high_zero: assert property (rise && op_q == 8'h5A
        && cnt_q inside {[12'h008:12'h017]} |-> host_oe == 4'h1 && io[0] == 1'b0)
        else $error("discovery high address not zero");
    a_dummy_released: assert property (op_q == 8'h4B && cnt_q inside {[9:39]} |->
        (host_oe | dev_oe) == 4'h0) else $error("link driven during dummies");
    a_idle_clock_low: assert property (cs_n && $past(cs_n, 6) |-> !sclk)
        else $error("link clock runs while idle");
    c_quad: cover property (op_q == 8'h94 && $rose(dev_oe != 4'h0));
    c_unique: cover property (op_q == 8'h4B && $rose(dev_oe != 4'h0));
    c_disc: cover property (op_q == 8'h5A && $rose(dev_oe != 4'h0));
    c_std: cover property (op_q == 8'h9F && $rose(dev_oe != 4'h0));
endmodule // fidr_link_monitor

/* bench/fidr_bench.sv */
`timescale 1ns/1ps
module fidr_bench;
    typedef struct {string name; logic [31:0] val;} fidr_exp_t;
    // Identity values are arbitrary
    localparam logic [7:0] MAKER = 8'h3C;
    localparam logic [7:0] DEV = 8'hC3;
    localparam logic [7:0] TYP = 8'h5E;
    localparam logic [7:0] CAP = 8'h17;
    localparam logic [63:0] UID = 64'hFEDCBA9876543210;
    logic clock_i, rst_n_i, wr_i, rd_i, chk_q, pend_q;
    logic [7:0] addr_i, a;
    logic [31:0] wdata_i, rdata_o, seed, e;
    int n_mismatch, samples_checked;
    fidr_exp_t exp_q[$];
    logic [7:0] disc_tbl [14] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hFF,
        8'h00, 8'h00, 8'h01, 8'h09, 8'h80, 8'h00};
    fidr_link_if link ();
    fidr_host fidr_host_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link.host));
    fidr_device #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEV), .MEM_TYPE(TYP), .CAPACITY(CAP),
        .UNIQUE_ID(UID)) fidr_device_inst (.rst_n_i(rst_n_i), .link(link.dev));
    fidr_link_monitor fidr_link_monitor_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .cs_n(link.cs_n), .sclk(link.sclk), .host_io(link.host_io), .host_oe(link.host_oe),
        .dev_io(link.dev_io), .dev_oe(link.dev_oe), .io(link.io));
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Bytes past the header read as erased
    function automatic logic [7:0] tbl(input logic [7:0] b);
        return (b < 8'h0E) ? disc_tbl[b] : 8'hFF;
    endfunction
    task automatic tally_and_finish();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp_word(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    // One strobe cycle, then a gap so no signal is set twice in one step
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic c);
        @(posedge clock_i);
        wr_i <= w;
        rd_i <= ~w;
        addr_i <= ad;
        wdata_i <= d;
        chk_q <= c;
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask
    task automatic check_rd(input string n, input logic [7:0] ad, input logic [31:0] x);
        exp_q.push_back('{n, x});
        bus(1'b0, ad, 32'h0, 1'b1);
    endtask
    // Start a frame and poll the done flag under a bound
    task automatic run(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] n);
        logic [31:0] st;
        bus(1'b1, fidr_pkg::REG_ADDR, {8'h00, ad}, 1'b0);
        bus(1'b1, fidr_pkg::REG_COUNT, {24'h0, n}, 1'b0);
        bus(1'b1, fidr_pkg::REG_CTRL, 32'h100 | {24'h0, op}, 1'b0);
        st = 32'h0;
        for (int k = 0; k < 3000 && st[fidr_pkg::STAT_DONE_BIT] !== 1'b1; k++) begin
            bus(1'b0, fidr_pkg::REG_STATUS, 32'h0, 1'b0);
            #1 st = rdata_o;
        end
        // A frame that never finishes is a failure, not a silent skip
        if (st[fidr_pkg::STAT_DONE_BIT] !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clock_i) begin
        if (pend_q === 1'b1) begin
            cmp_word(exp_q[0].name, exp_q[0].val, rdata_o);
            void'(exp_q.pop_front());
        end
        pend_q <= rd_i & chk_q;
    end
    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        {wr_i, rd_i, chk_q, pend_q, addr_i, wdata_i} = '0;
        {n_mismatch, samples_checked} = '0;
        seed = 32'h654D;
        // A real falling edge at start, so the link end's asynchronous reset cannot be missed
        rst_n_i = 1'b1;
        #1 rst_n_i = 1'b0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        check_rd("unmapped", 8'h20, 32'h0);
        run(8'h9F, 24'h0, 8'd4);
        check_rd("std_id", fidr_pkg::REG_RX_LO, {MAKER, TYP, CAP, 8'hFF});
        run(8'h94, 24'h0, 8'd4);
        check_rd("quad_id", fidr_pkg::REG_RX_LO, {MAKER, DEV, MAKER, DEV});
        run(8'h94, 24'h1, 8'd4);
        check_rd("quad_swap", fidr_pkg::REG_RX_LO, {DEV, MAKER, DEV, MAKER});
        run(8'h3C, 24'h0, 8'd2);
        repeat (2) begin
            run(8'h4B, 24'h0, 8'd8);
            check_rd("uid_hi", fidr_pkg::REG_RX_HI, UID[63:32]);
            check_rd("uid_lo", fidr_pkg::REG_RX_LO, UID[31:0]);
        end
        run(8'h5A, 24'h0, 8'd8);
        check_rd("sig", fidr_pkg::REG_RX_HI, 32'h53464450);
        check_rd("rev", fidr_pkg::REG_RX_LO, 32'h000100FF);
        run(8'h5A, 24'h8, 8'd8);
        check_rd("hdr_hi", fidr_pkg::REG_RX_HI, 32'h00000109);
        check_rd("hdr_lo", fidr_pkg::REG_RX_LO, 32'h8000FFFF);
        // Random start bytes; with this seed none of them wraps past the top
        repeat (5) begin
            seed = xs(seed);
            a = seed[7:0];
            e = 32'h0;
            for (int k = 0; k < 4; k++) e = {e[23:0], tbl(a + 8'(k))};
            run(8'h5A, {16'h0, a}, 8'd4);
            check_rd("disc_rand", fidr_pkg::REG_RX_LO, e);
        end
        repeat (3) @(posedge clock_i);
        tally_and_finish();
    end
endmodule // fidr_bench
